// ==== inc/gain_if.sv ====
`default_nettype none
interface gain_if;
	logic [14:0] gmax;
	logic [6:0] pct;
	logic [15:0] speed;
	logic scale_en;
	logic [14:0] gain;
	modport cfg(output gmax, output pct, output speed, output scale_en,
		input gain);
	modport calc(input gmax, input pct, input speed, input scale_en,
		output gain);
endinterface
`default_nettype wire

// ==== inc/servo_cfg_defs.svh ====
`ifndef SERVO_CFG_DEFS_SVH
`define SERVO_CFG_DEFS_SVH

// register byte offsets
`define A_PEAK 8'h00
`define A_AVG 8'h04
`define A_DB 8'h08
`define A_DGP 8'h0c
`define A_DGM 8'h10
`define A_IGP 8'h14
`define A_IGM 8'h18
`define A_IL 8'h1c
`define A_GSW 8'h20
`define A_ST 8'h24
`define A_MASK 8'h28
`define A_CTRL 8'h2c

// limits and reset values, currents in mA, speed in milli-rps
`define PEAK_MAX 16'h2134
`define AVG_MAX 16'h1d4c
`define DB_MAX 28'ha000000
`define DB_RST 28'h0000000
`define PCT_MAX 7'h63
`define DGP_RST 7'h1e
`define IGP_RST 7'h32
`define GMAX_MAX 15'h7fff
`define DGM_RST 15'h0190
`define IGM_RST 15'h2328
`define IL_MAX 31'h7fffffff
`define IL_RST 31'h0000ffff
`define PCT_DIV 7'h64
`define SPEED_FULL 16'h07d0
`define HIRES_SHIFT 4

// status bits
`define ST_PEAK 0
`define ST_AVG 1
`define ST_SLIP 2
`define ST_W 3

`endif

// ==== inc/servo_cfg_pkg.sv ====
`default_nettype none
package servo_cfg_pkg;
	typedef logic [15:0] cur_t;
	typedef logic [6:0] pct_t;
	typedef logic [14:0] gain_t;
	// gain switching mode codes, 0 is the bare query
	typedef enum logic [2:0] {
		GS_QUERY, GS_DERIV_OFF, GS_DERIV_ON, GS_TORQ_OFF, GS_TORQ_ON
	} gsw_code_t;
endpackage
`default_nettype wire

// ==== src/gain_scale.sv ====
`include "servo_cfg_defs.svh"
`default_nettype none
module gain_scale
	import servo_cfg_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_n,
	gain_if.calc g
);
	logic [21:0] prod;
	gain_t base;
	logic [30:0] sprod;
	gain_t nxt_gain;
	gain_t gain_ff;

	// percentage of maximum, then optional speed taper
	always_comb begin
		prod = g.gmax * g.pct;
		base = 15'(prod / `PCT_DIV);
		sprod = base * g.speed;
		nxt_gain = base;
		if (g.scale_en && g.speed < `SPEED_FULL) begin
			nxt_gain = 15'(sprod / `SPEED_FULL);
		end
	end

	// registered gain
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			gain_ff <= '0;
		end else begin
			gain_ff <= nxt_gain;
		end
	end
	assign g.gain = gain_ff;

	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	property p_pct_scale;
		!g.scale_en |=> g.gain == $past(base);
	endproperty
	a_pct_scale: assert property (p_pct_scale)
		else $error("gain is not max times percent over 100");

	property p_taper_zero;
		g.scale_en && g.speed == 16'h0000 |=> g.gain == 15'h0000;
	endproperty
	a_taper_zero: assert property (p_taper_zero)
		else $error("derivative gain not zero at standstill");

	property p_taper_full;
		g.scale_en && g.speed >= `SPEED_FULL |=> g.gain == $past(base);
	endproperty
	a_taper_full: assert property (p_taper_full)
		else $error("derivative gain not full above 2 rps");
endmodule
`default_nettype wire

// ==== src/servo_gain_and_current_limit_config.sv ====
`include "servo_cfg_defs.svh"
`default_nettype none
module servo_gain_and_current_limit_config
	import servo_cfg_pkg::*;
#(
	parameter logic [15:0] TORQ_THRESH = 16'h0100
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr_stb,
	input wire logic rd_stb,
	output logic [31:0] rd_data,
	input wire logic [15:0] meas_current,
	input wire logic [15:0] avg_current,
	input wire logic signed [31:0] following_error,
	input wire logic [15:0] motor_speed,
	input wire logic loop_tick,
	input wire logic signed [31:0] integ_err,
	input wire logic signed [15:0] loop_torque,
	output logic amp_enable,
	output logic fault,
	output logic slip_fault,
	output logic irq,
	output logic [14:0] d_gain,
	output logic [14:0] i_gain,
	output logic [31:0] integ_sum,
	output logic torque_hires,
	output logic [19:0] amp_torque
);
	cur_t peak_ff, avg_lim_ff;
	logic [27:0] db_ff;
	pct_t dg_pct_ff, ig_pct_ff;
	gain_t dg_max_ff, ig_max_ff;
	logic [30:0] il_ff;
	logic deriv_sw_ff, torq_sw_ff;
	logic [`ST_W-1:0] st_ff, mask_ff, nxt_st, ev;
	logic amp_en_ff, fault_ff, slip_ff, irq_ff, hires_ff;
	logic [31:0] rd_data_ff, rmux;
	logic [19:0] amp_torque_ff;
	logic [31:0] isum_ff, nxt_isum;
	logic signed [32:0] acc, lim_p, lim_n;
	logic peak_trip, avg_trip, slip_now, small_tq;
	logic w_any;

	function automatic logic fits(input logic [31:0] v, input logic [31:0] m);
		return v <= m;
	endfunction

	function automatic logic [31:0] mag32(input logic [31:0] v);
		return v[31] ? 32'(-v) : v;
	endfunction

	// supervision comparisons
	assign peak_trip = meas_current > peak_ff;
	assign avg_trip = amp_en_ff && avg_current > avg_lim_ff;
	assign slip_now = mag32(following_error) > {4'h0, db_ff};
	assign small_tq = mag32(32'(loop_torque)) < {16'h0000, TORQ_THRESH};
	assign w_any = wr_stb;

	// limit and gain settings, out of range writes ignored
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			peak_ff <= `PEAK_MAX;
			avg_lim_ff <= `AVG_MAX;
			db_ff <= `DB_RST;
			dg_pct_ff <= `DGP_RST;
			dg_max_ff <= `DGM_RST;
			ig_pct_ff <= `IGP_RST;
			ig_max_ff <= `IGM_RST;
			il_ff <= `IL_RST;
		end else if (w_any) begin
			if (addr == `A_PEAK && fits(wdata, 32'(`PEAK_MAX))) begin
				peak_ff <= wdata[15:0];
			end
			if (addr == `A_AVG && fits(wdata, 32'(`AVG_MAX))) begin
				avg_lim_ff <= wdata[15:0];
			end
			if (addr == `A_DB && fits(wdata, 32'(`DB_MAX))) begin
				db_ff <= wdata[27:0];
			end
			if (addr == `A_DGP && fits(wdata, 32'(`PCT_MAX))) begin
				dg_pct_ff <= wdata[6:0];
			end
			if (addr == `A_DGM && fits(wdata, 32'(`GMAX_MAX))) begin
				dg_max_ff <= wdata[14:0];
			end
			if (addr == `A_IGP && fits(wdata, 32'(`PCT_MAX))) begin
				ig_pct_ff <= wdata[6:0];
			end
			if (addr == `A_IGM && fits(wdata, 32'(`GMAX_MAX))) begin
				ig_max_ff <= wdata[14:0];
			end
			if (addr == `A_IL && fits(wdata, 32'(`IL_MAX))) begin
				il_ff <= wdata[30:0];
			end
		end
	end

	// gain switching mode decode, code 0 only reports
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			deriv_sw_ff <= 1'b0;
			torq_sw_ff <= 1'b1;
		end else if (wr_stb && addr == `A_GSW && wdata[31:3] == 29'h0) begin
			unique case (gsw_code_t'(wdata[2:0]))
				GS_QUERY: begin
				end
				GS_DERIV_OFF: deriv_sw_ff <= 1'b0;
				GS_DERIV_ON: deriv_sw_ff <= 1'b1;
				GS_TORQ_OFF: torq_sw_ff <= 1'b0;
				GS_TORQ_ON: torq_sw_ff <= 1'b1;
				default: begin
				end
			endcase
		end
	end

	// amplifier enable and error flag, trips win over software
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			amp_en_ff <= 1'b0;
			fault_ff <= 1'b0;
		end else if (peak_trip || avg_trip) begin
			amp_en_ff <= 1'b0;
			fault_ff <= 1'b1;
		end else if (wr_stb && addr == `A_CTRL) begin
			amp_en_ff <= wdata[0];
			if (wdata[0]) begin
				fault_ff <= 1'b0;
			end
		end
	end

	// sticky status, write one to clear, set wins
	always_comb begin
		ev = '0;
		ev[`ST_PEAK] = peak_trip;
		ev[`ST_AVG] = avg_trip;
		ev[`ST_SLIP] = slip_now;
		nxt_st = st_ff;
		if (wr_stb && addr == `A_ST) begin
			nxt_st = st_ff & ~wdata[`ST_W-1:0];
		end
		nxt_st = nxt_st | ev;
	end

	// status, mask and interrupt line
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_ff <= '0;
			mask_ff <= '0;
			irq_ff <= 1'b0;
		end else begin
			st_ff <= nxt_st;
			if (wr_stb && addr == `A_MASK) begin
				mask_ff <= wdata[`ST_W-1:0];
			end
			irq_ff <= |(nxt_st & mask_ff);
		end
	end

	// slip fault output
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			slip_ff <= 1'b0;
		end else begin
			slip_ff <= slip_now;
		end
	end

	// torque resolution switching
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			hires_ff <= 1'b0;
			amp_torque_ff <= '0;
		end else begin
			hires_ff <= torq_sw_ff && small_tq;
			if (torq_sw_ff && small_tq) begin
				amp_torque_ff <= {loop_torque, `HIRES_SHIFT'(0)};
			end else begin
				amp_torque_ff <= 20'(loop_torque);
			end
		end
	end

	// integrator accumulate and clamp to the sum limit
	assign lim_p = $signed({2'b00, il_ff});
	assign lim_n = -lim_p;
	always_comb begin
		acc = $signed({isum_ff[31], isum_ff});
		if (loop_tick) begin
			acc = acc + $signed({integ_err[31], integ_err});
		end
		if (acc > lim_p) begin
			nxt_isum = lim_p[31:0];
		end else if (acc < lim_n) begin
			nxt_isum = lim_n[31:0];
		end else begin
			nxt_isum = acc[31:0];
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			isum_ff <= '0;
		end else begin
			isum_ff <= nxt_isum;
		end
	end

	// read mux, unmapped reads give zero
	always_comb begin
		unique case (addr)
			`A_PEAK: rmux = 32'(peak_ff);
			`A_AVG: rmux = 32'(avg_lim_ff);
			`A_DB: rmux = 32'(db_ff);
			`A_DGP: rmux = 32'(dg_pct_ff);
			`A_DGM: rmux = 32'(dg_max_ff);
			`A_IGP: rmux = 32'(ig_pct_ff);
			`A_IGM: rmux = 32'(ig_max_ff);
			`A_IL: rmux = 32'(il_ff);
			`A_GSW: rmux = {30'h0, torq_sw_ff, deriv_sw_ff};
			`A_ST: rmux = 32'(st_ff);
			`A_MASK: rmux = 32'(mask_ff);
			`A_CTRL: rmux = {30'h0, fault_ff, amp_en_ff};
			default: rmux = '0;
		endcase
	end

	// read data stands only in the cycle after the strobe
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_data_ff <= '0;
		end else begin
			rd_data_ff <= rd_stb ? rmux : 32'h0000_0000;
		end
	end

	// effective gains
	gain_if dg_if();
	gain_if ig_if();
	assign dg_if.gmax = dg_max_ff;
	assign dg_if.pct = dg_pct_ff;
	assign dg_if.speed = motor_speed;
	assign dg_if.scale_en = deriv_sw_ff;
	assign ig_if.gmax = ig_max_ff;
	assign ig_if.pct = ig_pct_ff;
	assign ig_if.speed = motor_speed;
	assign ig_if.scale_en = 1'b0;

	gain_scale u_dgain (.core_clk(core_clk), .rst_n(rst_n), .g(dg_if));
	gain_scale u_igain (.core_clk(core_clk), .rst_n(rst_n), .g(ig_if));

	// outputs
	assign rd_data = rd_data_ff;
	assign amp_enable = amp_en_ff;
	assign fault = fault_ff;
	assign slip_fault = slip_ff;
	assign irq = irq_ff;
	assign d_gain = dg_if.gain;
	assign i_gain = ig_if.gain;
	assign integ_sum = isum_ff;
	assign torque_hires = hires_ff;
	assign amp_torque = amp_torque_ff;

	// checks
	logic seen_ff;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			seen_ff <= 1'b0;
		end else begin
			seen_ff <= 1'b1;
		end
	end

	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	sequence s_wr(logic [7:0] a);
		wr_stb && addr == a;
	endsequence

	property p_peak_trip;
		peak_trip |=> !amp_enable && fault && st_ff[`ST_PEAK];
	endproperty
	a_peak_trip: assert property (p_peak_trip)
		else $error("peak overcurrent did not disable amplifier");

	property p_peak_wr;
		s_wr(`A_PEAK) ##0 fits(wdata, 32'(`PEAK_MAX))
			|=> peak_ff == $past(wdata[15:0]);
	endproperty
	a_peak_wr: assert property (p_peak_wr)
		else $error("valid peak limit write not taken");

	property p_peak_range;
		peak_ff <= `PEAK_MAX;
	endproperty
	a_peak_range: assert property (p_peak_range)
		else $error("peak limit out of range");

	property p_slip_on;
		mag32(following_error) > {4'h0, db_ff} |=> slip_fault;
	endproperty
	a_slip_on: assert property (p_slip_on)
		else $error("slip fault missed");

	property p_slip_off;
		mag32(following_error) <= {4'h0, db_ff} |=> !slip_fault;
	endproperty
	a_slip_off: assert property (p_slip_off)
		else $error("slip fault inside dead band");

	property p_dg_pct;
		s_wr(`A_DGP) ##0 !fits(wdata, 32'(`PCT_MAX)) |=> $stable(dg_pct_ff);
	endproperty
	a_dg_pct: assert property (p_dg_pct)
		else $error("bad differential percent accepted");

	property p_dg_max;
		s_wr(`A_DGM) ##0 fits(wdata, 32'(`GMAX_MAX))
			|=> dg_max_ff == $past(wdata[14:0]);
	endproperty
	a_dg_max: assert property (p_dg_max)
		else $error("differential maximum not replaced");

	property p_hires;
		torq_sw_ff && small_tq |=> torque_hires
			&& amp_torque == {$past(loop_torque), `HIRES_SHIFT'(0)};
	endproperty
	a_hires: assert property (p_hires)
		else $error("high resolution torque not sent");

	property p_gs_decode;
		s_wr(`A_GSW) ##0 wdata == 32'h2 |=> deriv_sw_ff ##0 $stable(torq_sw_ff);
	endproperty
	a_gs_decode: assert property (p_gs_decode)
		else $error("mode code 2 not decoded");

	property p_defaults;
		!seen_ff |-> !deriv_sw_ff && torq_sw_ff;
	endproperty
	a_defaults: assert property (p_defaults)
		else $error("switching defaults wrong");

	property p_ig_pct;
		ig_pct_ff <= `PCT_MAX && dg_pct_ff <= `PCT_MAX;
	endproperty
	a_ig_pct: assert property (p_ig_pct)
		else $error("gain percent above 99");

	property p_clamp;
		1'b1 |=> mag32(integ_sum) <= 32'($past(il_ff));
	endproperty
	a_clamp: assert property (p_clamp)
		else $error("integrator sum beyond limit");

	property p_query;
		s_wr(`A_GSW) ##0 wdata == 32'h0
			|=> $stable(deriv_sw_ff) && $stable(torq_sw_ff);
	endproperty
	a_query: assert property (p_query)
		else $error("bare mode command changed state");

	property p_avg_trip;
		amp_en_ff && avg_current > avg_lim_ff |=> !amp_enable && fault;
	endproperty
	a_avg_trip: assert property (p_avg_trip)
		else $error("average overcurrent did not disable amplifier");

	property p_ig_max;
		s_wr(`A_IGM) ##0 fits(wdata, 32'(`GMAX_MAX))
			|=> ig_max_ff == $past(wdata[14:0]);
	endproperty
	a_ig_max: assert property (p_ig_max)
		else $error("integral maximum not replaced");
endmodule
`default_nettype wire

// ==== test/motor_side_model.sv ====
`default_nettype none
module motor_side_model (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic amp_enable,
	input wire logic [15:0] cur_set,
	output logic [15:0] meas_current
);
	timeunit 1ns;
	timeprecision 1ns;
	// motor current flows only while the amplifier is on
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			meas_current <= 16'h0000;
		end else if (amp_enable) begin
			meas_current <= cur_set;
		end else begin
			meas_current <= 16'h0000;
		end
	end
endmodule
`default_nettype wire

// ==== test/testbench.sv ====
`include "servo_cfg_defs.svh"
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [31:0] rd_data;
	logic [31:0] rng = 32'h40;
	logic [31:0] rv;
	logic wr_stb = 1'b0;
	logic rd_stb = 1'b0;
	logic loop_tick = 1'b0;
	logic [15:0] cur_set = 16'h0000;
	logic [15:0] meas_current;
	logic [15:0] avg_current = 16'h0000;
	logic [15:0] motor_speed = 16'h0000;
	logic signed [31:0] following_error = 32'h0;
	logic signed [31:0] integ_err = 32'h0;
	logic signed [15:0] loop_torque = 16'h0000;
	logic [31:0] integ_sum;
	logic amp_enable, fault, slip_fault, irq, torque_hires;
	logic [14:0] d_gain, i_gain;
	logic [19:0] amp_torque;
	int n_errors = 0;
	int samples_checked = 0;

	always #5 core_clk = ~core_clk;

	servo_gain_and_current_limit_config servo_gain_and_current_limit_config_inst (
		.core_clk(core_clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
		.wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data),
		.meas_current(meas_current), .avg_current(avg_current),
		.following_error(following_error), .motor_speed(motor_speed),
		.loop_tick(loop_tick), .integ_err(integ_err),
		.loop_torque(loop_torque), .amp_enable(amp_enable), .fault(fault),
		.slip_fault(slip_fault), .irq(irq), .d_gain(d_gain),
		.i_gain(i_gain), .integ_sum(integ_sum),
		.torque_hires(torque_hires), .amp_torque(amp_torque));
	motor_side_model motor_side_model_inst (.core_clk(core_clk),
		.rst_n(rst_n), .amp_enable(amp_enable), .cur_set(cur_set),
		.meas_current(meas_current));

	// xorshift source, seeded at 64
	function automatic logic [31:0] rnd();
		rng = rng ^ (rng << 13);
		rng = rng ^ (rng >> 17);
		rng = rng ^ (rng << 5);
		return rng;
	endfunction
	// expected gain: max * pct / 100, tapered below full speed
	function automatic logic [14:0] gexp(input logic [14:0] m,
		input logic [6:0] p, input logic [15:0] s);
		logic [31:0] g;
		g = m * p / 32'h64;
		if (s < 16'h07d0) g = g * s / 32'h7d0;
		return g[14:0];
	endfunction
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		addr <= a;
		wdata <= d;
		wr_stb <= 1'b1;
		@(posedge core_clk);
		wr_stb <= 1'b0;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		@(posedge core_clk);
		addr <= a;
		rd_stb <= 1'b1;
		@(posedge core_clk);
		rd_stb <= 1'b0;
		#1;
		chk(rd_data, e);
	endtask
	task automatic conclude();
		$display("checked %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask

	// hang guard
	initial begin
		repeat (60000) @(posedge core_clk);
		n_errors++;
		conclude();
	end

	initial begin : main
		logic [31:0] db, m, p, m2, p2;
		int i;
		repeat (5) @(posedge core_clk);
		rst_n <= 1'b1;
		tick(2);
		// settings after reset, plus an unmapped read
		rchk(`A_PEAK, 32'h2134);
		rchk(`A_AVG, 32'h1d4c);
		rchk(`A_DB, 32'h0);
		rchk(`A_DGP, 32'h1e);
		rchk(`A_DGM, 32'h190);
		rchk(`A_IGP, 32'h32);
		rchk(`A_IGM, 32'h2328);
		rchk(`A_IL, 32'hffff);
		rchk(`A_GSW, 32'h2);
		rchk(8'h30, 32'h0);
		chk(d_gain, 32'h78);
		chk(i_gain, 32'h1194);
		$display("test reset done");
		// peak trip at a lowered limit, interrupt raise and clear
		wr(`A_PEAK, 32'h2135);
		rchk(`A_PEAK, 32'h2134);
		wr(`A_PEAK, 32'hfa0);
		wr(`A_MASK, 32'h7);
		wr(`A_CTRL, 32'h1);
		cur_set <= 16'h0fa0;
		tick(4);
		chk(amp_enable, 32'h1);
		chk(irq, 32'h0);
		cur_set <= 16'h0fa1;
		tick(4);
		chk({fault, amp_enable}, 32'h2);
		chk(irq, 32'h1);
		rchk(`A_ST, 32'h1);
		wr(`A_ST, 32'h1);
		tick(2);
		chk(irq, 32'h0);
		$display("test peak done");
		// average trip only above its limit
		cur_set <= 16'h0000;
		wr(`A_CTRL, 32'h1);
		avg_current <= 16'h1d4c;
		tick(3);
		chk({fault, amp_enable}, 32'h1);
		avg_current <= 16'h1d4d;
		tick(3);
		chk({fault, amp_enable}, 32'h2);
		rchk(`A_ST, 32'h2);
		avg_current <= 16'h0000;
		wr(`A_ST, 32'h2);
		$display("test average done");
		// slip window edges at random dead bands and the largest one
		for (i = 0; i < 8; i++) begin
			db = rnd() % 32'ha000001;
			if (i == 1) db = 32'ha000000;
			wr(`A_DB, db);
			following_error <= i[0] ? -db : db;
			tick(3);
			chk(slip_fault, 32'h0);
			following_error <= i[0] ? -(db + 1) : db + 1;
			tick(3);
			chk(slip_fault, 32'h1);
		end
		wr(`A_DB, 32'ha000001);
		rchk(`A_DB, db);
		following_error <= 32'h0;
		wr(`A_ST, 32'h4);
		$display("test slip done");
		// random gain settings, out-of-range percent ignored
		for (i = 0; i < 8; i++) begin
			m = rnd() & 32'h7fff;
			p = rnd() % 32'h64;
			m2 = rnd() & 32'h7fff;
			p2 = rnd() % 32'h64;
			if (i == 0) m = 32'h7fff;
			if (i == 0) p = 32'h63;
			wr(`A_DGM, m);
			wr(`A_DGP, p);
			wr(`A_IGM, m2);
			wr(`A_IGP, p2);
			wr(`A_DGP, 32'h64);
			wr(`A_IGM, 32'h8000);
			tick(3);
			chk(d_gain, gexp(m[14:0], p[6:0], 16'hffff));
			chk(i_gain, gexp(m2[14:0], p2[6:0], 16'hffff));
		end
		$display("test gains done");
		// every mode code, the bare query and both switching effects
		wr(`A_GSW, 32'h2);
		motor_speed <= 16'h03e8;
		tick(3);
		chk(d_gain, gexp(m[14:0], p[6:0], 16'h03e8));
		rchk(`A_GSW, 32'h3);
		wr(`A_GSW, 32'h0);
		rchk(`A_GSW, 32'h3);
		wr(`A_GSW, 32'h1);
		loop_torque <= 16'hff01;
		tick(3);
		chk(d_gain, gexp(m[14:0], p[6:0], 16'hffff));
		chk(torque_hires, 32'h1);
		chk(amp_torque, 32'hff010);
		wr(`A_GSW, 32'h3);
		tick(3);
		chk(torque_hires, 32'h0);
		chk(amp_torque, 32'hfff01);
		rchk(`A_GSW, 32'h0);
		wr(`A_GSW, 32'h4);
		rchk(`A_GSW, 32'h2);
		$display("test switching done");
		// integrator clamp both ways
		// a new sum limit is kept only for this run; no save follows it
		wr(`A_IL, 32'h64);
		integ_err <= 32'h3c;
		loop_tick <= 1'b1;
		tick(4);
		chk(integ_sum, 32'h64);
		integ_err <= 32'hffffffc4;
		tick(8);
		chk(integ_sum, 32'hffffff9c);
		loop_tick <= 1'b0;
		$display("test integrator done");
		conclude();
	end
endmodule
`default_nettype wire
